// ### hdl/ctmpm_ctrl.sv
// Clock test-mode, divider programming and power-management control
// Contract
// - Bytes 0x16/0x17 hold CPU N[8] at bit 7 and N[9] at bit 6 on top, M[5:0], then N[7:0].
// - Power-up M and N come from strap-latched default table, not constant.
// - Power byte bit 0 keeps crystal on in power-down; resets 1, upper 0.
// - Power byte bit 1 enables storage-link PLL; resets off.
// - Strap sampled at power-up above threshold means test-select, else frequency select.
// - Test-select latched high enters hardware test mode: hi-Z or divided reference.
// - Hardware test: pin high gives reference; low gives hi-Z unless select bit.
// - Strap low: writing entry bit 3 of byte 9 enters test mode.
// - Software test mode: only bit 4 picks reference or hi-Z; pin ignored.
// - Test mode is sticky until power cycles; clearing entry bit does nothing.
// - Strap low and entry bit never set since power-up gives normal outputs regardless of pin.
`timescale 1ns/1ps
module ctmpm_ctrl
    import ctmpm_pkg::*;
(
    input  wire logic        ref_clk,            // 25 MHz clock
    input  wire logic        rst,                // Power-on reset, sync high
    input  wire logic        ce,                 // Clock enable
    input  wire logic        test_sel_high,      // Comparator: strap above threshold
    input  wire logic        freq_select_c,      // Frequency strap c (pin)
    input  wire logic        freq_select_b,      // Frequency strap b / test-mode pin
    input  wire logic        freq_select_a,      // Frequency strap a (pin)
    input  wire logic        reg_wr,             // Byte write strobe
    input  wire logic        reg_rd,             // Byte read strobe
    input  wire logic [7:0]  reg_addr,           // Byte index
    input  wire logic [7:0]  reg_wdata,          // Write data
    output logic      [7:0]  reg_rdata,          // Read data
    output logic             reg_rsv_access,     // Reserved byte touched
    output logic      [5:0]  cpu_m_div,          // CPU reference divider
    output logic      [9:0]  cpu_n_div,          // CPU VCO divider
    output logic             crystal_powerdown_ctrl,  // Crystal on in power-down
    output logic             storage_link_pll_enable, // Storage-link PLL on
    output logic             test_mode,          // Test mode active
    output logic             out_normal,         // Outputs run normally
    output logic             out_hiz,            // Outputs high-impedance
    output logic             out_refdiv          // Outputs carry divided reference
);
    logic [2:0] pins_s;
    logic       strap_done;
    logic       strap_test;
    logic [7:0] cpu_hi;
    logic [7:0] cpu_lo;
    logic [7:0] pm;
    logic [7:0] cfg9;
    logic       hw_test;
    logic       sw_test;
    ctmpm_out_t next_out;
    ctmpm_out_t out_state;

    ctmpm_sync #(.W(3)) ctmpm_sync_i (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .d       ({test_sel_high, freq_select_b, freq_select_a}),
        .q       (pins_s)
    );

    // Strap is caught once after release, so the pin stays free afterwards
    logic       fsc_s1;
    logic       fsc_s2;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            fsc_s1 <= 1'b0;
            fsc_s2 <= 1'b0;
        end
        else if (ce)
        begin
            fsc_s1 <= freq_select_c;
            fsc_s2 <= fsc_s1;
        end
    end

    logic [1:0] settle;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            settle     <= 2'h0;
            strap_done <= 1'b0;
            strap_test <= 1'b0;
        end
        else if (ce && !strap_done)
        begin
            settle <= settle + 2'h1;
            if (settle == 2'h2)
            begin
                strap_done <= 1'b1;
                strap_test <= pins_s[2];
            end
        end
    end

    // Strap as test-select leaves freq c read as zero
    logic [15:0] rom_val;
    assign rom_val = ctmpm_rom({pins_s[2] ? 1'b0 : fsc_s2, pins_s[1], pins_s[0]});

    // Divider registers: load from table at strap latch, then host owned
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cpu_hi <= 8'h00;
            cpu_lo <= 8'h00;
        end
        else if (ce)
        begin
            if (!strap_done && settle == 2'h2)
            begin
                cpu_hi <= {rom_val[8], rom_val[9], rom_val[15:10]};
                cpu_lo <= rom_val[7:0];
            end
            else if (reg_wr && reg_addr == CTMPM_ADDR_CPU_HI)
                cpu_hi <= reg_wdata;
            else if (reg_wr && reg_addr == CTMPM_ADDR_CPU_LO)
                cpu_lo <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pm <= CTMPM_PM_RESET;
        else if (ce && reg_wr && reg_addr == CTMPM_ADDR_PM)
            pm <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cfg9 <= CTMPM_CFG9_RESET;
        else if (ce && reg_wr && reg_addr == CTMPM_ADDR_CFG9)
            cfg9 <= reg_wdata;
    end

    // Sticky test entry; only reset clears it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            hw_test <= 1'b0;
            sw_test <= 1'b0;
        end
        else if (ce)
        begin
            if (!strap_done && settle == 2'h2 && pins_s[2])
                hw_test <= 1'b1;
            if (strap_done && !strap_test && cfg9[CTMPM_CFG9_ENTRY])
                sw_test <= 1'b1;
        end
    end

    always_comb
    begin
        next_out = CTMPM_OUT_NORMAL;
        if (hw_test)
            next_out = (pins_s[1] || cfg9[CTMPM_CFG9_OUTSEL])
                       ? CTMPM_OUT_REFDIV : CTMPM_OUT_HIZ;
        else if (sw_test)
            next_out = cfg9[CTMPM_CFG9_OUTSEL]
                       ? CTMPM_OUT_REFDIV : CTMPM_OUT_HIZ;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            out_state <= CTMPM_OUT_NORMAL;
        else if (ce)
            out_state <= next_out;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            reg_rdata      <= 8'h00;
            reg_rsv_access <= 1'b0;
        end
        else if (ce)
        begin
            // reserved bytes read zero and are flagged, nothing is stored
            reg_rsv_access <= (reg_rd || reg_wr) &&
                              reg_addr >= CTMPM_RSV_FIRST && reg_addr <= CTMPM_RSV_LAST;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    CTMPM_ADDR_CPU_HI: reg_rdata <= cpu_hi;
                    CTMPM_ADDR_CPU_LO: reg_rdata <= cpu_lo;
                    CTMPM_ADDR_PM:     reg_rdata <= pm;
                    CTMPM_ADDR_CFG9:   reg_rdata <= cfg9;
                    default:           reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    assign cpu_m_div = cpu_hi[CTMPM_MDIV_W-1:0];
    assign cpu_n_div = {cpu_hi[CTMPM_HI_NDIV9_BIT], cpu_hi[CTMPM_HI_NDIV8_BIT], cpu_lo};
    assign crystal_powerdown_ctrl  = pm[CTMPM_PM_XTAL_BIT];
    assign storage_link_pll_enable = pm[CTMPM_PM_SLPLL_BIT];
    assign test_mode  = hw_test | sw_test;
    assign out_normal = out_state == CTMPM_OUT_NORMAL;
    assign out_hiz    = out_state == CTMPM_OUT_HIZ;
    assign out_refdiv = out_state == CTMPM_OUT_REFDIV;

    a_pm_reset_val: assert property (@(posedge ref_clk) $fell(rst) |-> pm == 8'h01)
        else $error("power byte reset value wrong");
    a_slpll_off: assert property (@(posedge ref_clk) $fell(rst) |-> !storage_link_pll_enable)
        else $error("storage-link PLL not off after reset");
    a_test_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        test_mode |=> test_mode)
        else $error("test mode left without power cycle");
    a_normal_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (!test_mode && ce) |=> out_normal)
        else $error("outputs not normal outside test mode");
    a_hw_pin_ref: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && hw_test && pins_s[1]) |=> out_refdiv)
        else $error("pin high did not give reference");
    a_hw_pin_hiz: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && hw_test && !pins_s[1] && !cfg9[CTMPM_CFG9_OUTSEL]) |=> out_hiz)
        else $error("pin low did not give hi-Z");
    a_sw_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && strap_done && !strap_test && cfg9[CTMPM_CFG9_ENTRY]) |=> sw_test)
        else $error("software entry not taken");
    a_sw_select: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && sw_test && !hw_test) |=> out_refdiv == $past(cfg9[CTMPM_CFG9_OUTSEL]))
        else $error("software select ignored");
    a_hw_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (strap_done && strap_test) |-> hw_test)
        else $error("strap high did not enter test mode");
    a_sw_blocked: assert property (@(posedge ref_clk) disable iff (rst)
        strap_test |-> !sw_test)
        else $error("software entry with strap as test-select");
endmodule // ctmpm_ctrl

// ### hdl/ctmpm_pkg.sv
// Constants for the clock test-mode and power-management control block
package ctmpm_pkg;
    localparam logic [7:0] CTMPM_ADDR_CPU_HI   = 8'h16;
    localparam logic [7:0] CTMPM_ADDR_CPU_LO   = 8'h17;
    localparam logic [7:0] CTMPM_ADDR_PM       = 8'h3F;
    localparam logic [7:0] CTMPM_ADDR_CFG9     = 8'h09;
    localparam logic [7:0] CTMPM_RSV_FIRST     = 8'h18;
    localparam logic [7:0] CTMPM_RSV_LAST      = 8'h3E;
    localparam int         CTMPM_HI_NDIV8_BIT  = 7;
    localparam int         CTMPM_HI_NDIV9_BIT  = 6;
    localparam int         CTMPM_MDIV_W        = 6;
    localparam int         CTMPM_NDIV_W        = 10;
    localparam int         CTMPM_PM_XTAL_BIT   = 0;
    localparam int         CTMPM_PM_SLPLL_BIT  = 1;
    localparam logic [7:0] CTMPM_PM_RESET      = 8'h01;
    localparam int         CTMPM_CFG9_ENTRY    = 3;
    localparam int         CTMPM_CFG9_OUTSEL   = 4;
    localparam logic [7:0] CTMPM_CFG9_RESET    = 8'h00;
    typedef enum logic [2:0]
    {
        CTMPM_OUT_NORMAL = 3'b001,
        CTMPM_OUT_HIZ    = 3'b010,
        CTMPM_OUT_REFDIV = 3'b100
    } ctmpm_out_t;
    // Built-in default table indexed by frequency-select code {c,b,a}: {M, N}
    function automatic logic [15:0] ctmpm_rom(input logic [2:0] fs);
        case (fs)
            3'd0:    ctmpm_rom = {6'h0C, 10'h0FA};
            3'd1:    ctmpm_rom = {6'h0C, 10'h07D};
            3'd2:    ctmpm_rom = {6'h0C, 10'h0BC};
            3'd3:    ctmpm_rom = {6'h0C, 10'h09C};
            3'd4:    ctmpm_rom = {6'h0C, 10'h138};
            3'd5:    ctmpm_rom = {6'h0C, 10'h05E};
            3'd6:    ctmpm_rom = {6'h0C, 10'h177};
            default: ctmpm_rom = {6'h0C, 10'h09C};
        endcase
    endfunction
endpackage

// ### hdl/ctmpm_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module ctmpm_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk, // Clock
    input  wire logic         rst,     // Sync reset
    input  wire logic         ce,      // Clock enable
    input  wire logic [W-1:0] d,       // Asynchronous level
    output logic      [W-1:0] q        // Synchronised level
);
    logic [W-1:0] stage1;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stage1 <= '0;
            q      <= '0;
        end
        else if (ce)
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // ctmpm_sync

// ### verification/ctmpm_ctrl_tb.sv
// Self-checking bench for the control block
`timescale 1ns/1ps
module ctmpm_ctrl_tb;
    import ctmpm_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       shi     = 1'b0;
    logic [2:0] fs      = 3'h5;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wd      = 8'h00;
    logic       tsh, fc, fb, fa, rsv, xo, sp, tm, on, oh, orf;
    logic [7:0] rdata;
    logic       rsv_seen = 1'b0;
    logic [5:0] m;
    logic [9:0] n;
    int         error_cnt = 0;
    int         cmp_count = 0;
    always #20 ref_clk = ~ref_clk;
    ctmpm_strap_model ctmpm_strap_model_i (.strap_hi(shi), .fs(fs), .test_sel_high(tsh),
        .freq_select_c(fc), .freq_select_b(fb), .freq_select_a(fa));
    ctmpm_ctrl ctmpm_ctrl_i (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .test_sel_high(tsh),
        .freq_select_c(fc), .freq_select_b(fb), .freq_select_a(fa), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
        .reg_rsv_access(rsv), .cpu_m_div(m), .cpu_n_div(n), .crystal_powerdown_ctrl(xo),
        .storage_link_pll_enable(sp), .test_mode(tm), .out_normal(on), .out_hiz(oh),
        .out_refdiv(orf));
    task automatic step(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd   = d;
        wr   = 1'b1;
        step(1);
        wr   = 1'b0;
        step(1);
    endtask
    // Read data stands until the next read; the reserved flag is a one-cycle pulse
    task automatic rdb(input logic [7:0] a);
        addr     = a;
        rd       = 1'b1;
        step(1);
        rsv_seen = rsv;
        rd       = 1'b0;
        step(1);
    endtask
    task automatic pwr(input logic s, input logic [2:0] f);
        shi = s;
        fs  = f;
        rst = 1'b1;
        step(16);
        rst = 1'b0;
        step(6);
    endtask
    task automatic outs(input logic [2:0] e);
        chk("outputs", 16'({on, oh, orf}), 16'(e));
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #1ms;
        error_cnt++;
        print_verdict;
    end
    initial
    begin
        step(1);
        pwr(1'b0, 3'h5);
        rdb(CTMPM_ADDR_PM);
        chk("pm", 16'(rdata), 16'h0001);
        chk("xtal", 16'(xo), 16'h0001);
        chk("slpll", 16'(sp), 16'h0000);
        rdb(CTMPM_ADDR_CFG9);
        chk("cfg9", 16'(rdata), 16'h0000);
        // Default table entry for code 5 is M 0x0C, N 0x05E
        chk("m", 16'(m), 16'h000C);
        chk("n", 16'(n), 16'h005E);
        rdb(CTMPM_ADDR_CPU_LO);
        chk("lo", 16'(rdata), 16'h005E);
        wrb(CTMPM_ADDR_CPU_HI, 8'hC5);
        wrb(CTMPM_ADDR_CPU_LO, 8'hA3);
        chk("m", 16'(m), 16'h0005);
        chk("n", 16'(n), 16'h03A3);
        rdb(CTMPM_ADDR_CPU_HI);
        chk("hi", 16'(rdata), 16'h00C5);
        rdb(8'h20);
        chk("rsvrd", 16'(rdata), 16'h0000);
        chk("rsvflag", 16'(rsv_seen), 16'h0001);
        wrb(CTMPM_RSV_LAST, 8'hFF);
        rdb(CTMPM_RSV_LAST);
        chk("rsvwr", 16'(rdata), 16'h0000);
        wrb(CTMPM_ADDR_PM, 8'h02);
        chk("xtal", 16'(xo), 16'h0000);
        chk("slpll", 16'(sp), 16'h0001);
        fs[1] = ~fs[1];
        step(5);
        outs(3'b100);
        wrb(CTMPM_ADDR_CFG9, 8'h08);
        step(2);
        outs(3'b010);
        chk("tm", 16'(tm), 16'h0001);
        fs[1] = ~fs[1];
        step(5);
        outs(3'b010);
        wrb(CTMPM_ADDR_CFG9, 8'h18);
        step(2);
        outs(3'b001);
        wrb(CTMPM_ADDR_CFG9, 8'h10);
        step(2);
        outs(3'b001);
        chk("tm", 16'(tm), 16'h0001);
        pwr(1'b1, 3'h6);
        outs(3'b001);
        // Strap c reads as zero when it serves as test-select: code 2 gives N 0x0BC
        chk("m", 16'(m), 16'h000C);
        chk("n", 16'(n), 16'h00BC);
        fs[1] = 1'b0;
        step(5);
        outs(3'b010);
        wrb(CTMPM_ADDR_CFG9, 8'h10);
        step(2);
        outs(3'b001);
        print_verdict;
    end
endmodule // ctmpm_ctrl_tb

// ### verification/ctmpm_strap_model.sv
// Board strap pins seen by the control block
`timescale 1ns/1ps
module ctmpm_strap_model (
    input  wire logic       strap_hi,      // Shared strap above threshold
    input  wire logic [2:0] fs,            // Strap levels {c,b,a}
    output logic            test_sel_high, // Comparator output
    output logic            freq_select_c, // Strap c
    output logic            freq_select_b, // Strap b, live test-mode pin
    output logic            freq_select_a  // Strap a
);
    // Levels pass straight through as the bench sets them; the block samples them through its synchroniser
    assign test_sel_high = strap_hi;
    assign freq_select_c = fs[2];
    assign freq_select_b = fs[1];
    assign freq_select_a = fs[0];
endmodule // ctmpm_strap_model
